//--- verilog/rcs_pkg.sv
package rcs_pkg;

  // ****************************************************************
  // register byte addresses (printed offsets are indices)
  // ****************************************************************
  localparam logic [7:0] IDX_SOFT_RESET   = 8'h00;
  localparam logic [7:0] IDX_SIGNAL_PRBS  = 8'h01;
  localparam logic [7:0] IDX_OBSERVE      = 8'h02;
  localparam logic [7:0] IDX_OBSERVE_SEL  = 8'h0C;
  localparam logic [7:0] IDX_LOAD_STATUS  = 8'h11;
  localparam logic [7:0] IDX_I2C_SPEED    = 8'h12;
  localparam logic [7:0] IDX_LOSS_ENABLE  = 8'h31;
  localparam logic [7:0] IDX_IRQ_STATUS   = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK     = 8'h41;

  localparam logic [9:0] ADDR_SOFT_RESET  = {IDX_SOFT_RESET, 2'h0};
  localparam logic [9:0] ADDR_SIGNAL_PRBS = {IDX_SIGNAL_PRBS, 2'h0};
  localparam logic [9:0] ADDR_OBSERVE     = {IDX_OBSERVE, 2'h0};
  localparam logic [9:0] ADDR_OBSERVE_SEL = {IDX_OBSERVE_SEL, 2'h0};
  localparam logic [9:0] ADDR_LOAD_STATUS = {IDX_LOAD_STATUS, 2'h0};
  localparam logic [9:0] ADDR_I2C_SPEED   = {IDX_I2C_SPEED, 2'h0};
  localparam logic [9:0] ADDR_LOSS_ENABLE = {IDX_LOSS_ENABLE, 2'h0};
  localparam logic [9:0] ADDR_IRQ_STATUS  = {IDX_IRQ_STATUS, 2'h0};
  localparam logic [9:0] ADDR_IRQ_MASK    = {IDX_IRQ_MASK, 2'h0};

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_REF_DOMAIN_SOFT_RESET   = 0;
  localparam int BIT_RST_RECOV    = 1;
  localparam int BIT_RST_REGS     = 2;
  localparam int BIT_RST_CORE     = 3;
  localparam int BIT_SIG_LOST     = 0;
  localparam int BIT_PAT_LSB      = 1;
  localparam int BIT_LOCK_LOST    = 5;
  localparam int BIT_PAT_INV      = 6;
  localparam int BIT_RAW_PRESENT  = 7;
  localparam int BIT_I2C_FAST     = 7;
  localparam int BIT_LOAD_FAIL    = 6;
  localparam int BIT_LOAD_DONE    = 7;
  localparam int BIT_SEL_LSB      = 4;
  localparam int BIT_EN_SIG_LOSS  = 0;
  localparam int BIT_EN_LOCK_LOSS = 1;

  // ****************************************************************
  // reset values and limits
  // ****************************************************************
  localparam logic [7:0] RST_SOFT_RESET = 8'h00;
  localparam logic [7:0] RST_I2C_SPEED  = 8'h91;
  localparam logic [7:0] RST_OBS_SEL    = 8'h00;
  localparam logic [7:0] RST_LOSS_EN    = 8'h00;
  localparam logic [1:0] RST_IRQ        = 2'h0;
  localparam logic [5:0] MAX_LOAD_TRIES = 6'h3F;

  // ****************************************************************
  // i2c rates at the 250 MHz pclk
  // ****************************************************************
  localparam int PCLK_HZ      = 250_000_000;
  localparam int I2C_FAST_HZ  = 400_000;
  localparam int I2C_STD_HZ   = 100_000;
  localparam int DIV_FAST     = PCLK_HZ / I2C_FAST_HZ;
  localparam int DIV_STD      = PCLK_HZ / I2C_STD_HZ;

  // ****************************************************************
  // detected pattern codes
  // ****************************************************************
  typedef enum logic [3:0] {
    RCS_PAT_NONE = 4'h0,
    RCS_PAT_7    = 4'h8,
    RCS_PAT_11   = 4'hA,
    RCS_PAT_15   = 4'hB,
    RCS_PAT_23   = 4'hC,
    RCS_PAT_31   = 4'hD,
    RCS_PAT_58   = 4'hE,
    RCS_PAT_63   = 4'hF
  } rcs_pat_t;

endpackage

//--- verilog/rcs_loss_flag.sv
// sticky loss flag: arms once the level is seen, sets when it then drops
module rcs_loss_flag (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic sync_clr,
  // event side
  input  wire logic enable,
  input  wire logic level,
  input  wire logic read_clr,
  // flag
  output logic      flag
);

  typedef struct packed {
    logic armed;
    logic flag;
  } rcs_loss_state_t;

  rcs_loss_state_t st_q;
  rcs_loss_state_t st_d;
  logic            fire;

  always_comb begin
    st_d = st_q;
    fire = 1'b0;
    if (sync_clr || !enable) begin
      st_d.armed = 1'b0;
      st_d.flag  = sync_clr ? 1'b0 : st_q.flag & ~read_clr;
    end else begin
      fire = st_q.armed && !level;
      if (level) begin
        st_d.armed = 1'b1;
      end else if (fire) begin
        st_d.armed = 1'b0;
      end
      // a new loss beats a clearing read
      st_d.flag = fire | (st_q.flag & ~read_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign flag = st_q.flag;

endmodule

//--- verilog/rcs_channel_regs.sv
// Behaviour
// RL1 - a read-only six-bit field counts configuration load attempts.
// RL2 - the load rate is 400 kHz when the speed bit is 1, else 100 kHz.
// RL3 - the core reset bit holds the core clock domain in reset.
// RL4 - the register reset bit returns channel registers to defaults; the speed register keeps its value here.
// RL5 - the recovered-clock reset bit resets the deserializer domain.
// RL6 - the reference reset bit resets the reference domain if it runs.
// RL7 - an enabled flag latches lock lost after lock; reading clears it.
// RL8 - an enabled flag latches signal lost after seen; reading clears it.
// RL9 - the pattern field is 0xxx for none, else the length code.
// RL10 - a read-only bit shows a polarity-inverted locked pattern.
// RL11 - the observe register shows the group picked by a select field.
// RL12 - a read-only bit shows the raw unfiltered signal detector.
// RL13 - load status bits: 00 busy, 10 done, 01 failed, 11 invalid.
// RL14 - each soft reset bit holds its domain while it reads one.
//
// Decided for this implementation: the APB register port.
module rcs_channel_regs #(
  parameter int unsigned DIV_FAST = rcs_pkg::DIV_FAST,
  parameter int unsigned DIV_STD  = rcs_pkg::DIV_STD
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // channel status inputs
  input  wire logic        raw_input_present,
  input  wire logic        cdr_locked,
  input  wire logic        pattern_inverted_flag,
  input  wire logic [3:0]  detected_pattern_code,
  input  wire logic [127:0] observe_groups,
  input  wire logic        ref_clk_present,
  // configuration loader
  input  wire logic        load_attempt_pulse,
  input  wire logic        load_done_flag,
  input  wire logic        load_failed_flag,
  output logic             i2c_scl_tick,
  output logic             i2c_fast_mode,
  // domain resets
  output logic             core_domain_reset,
  output logic             recovered_clk_soft_reset,
  output logic             ref_domain_soft_reset,
  // interrupt
  output logic             irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  soft_rst;
    logic [7:0]  i2c_speed;
    logic [7:0]  obs_sel;
    logic [7:0]  loss_en;
    logic [5:0]  attempts;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [15:0] div_cnt;
    logic        tick;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        core_rst;
    logic        recov_rst;
    logic        ref_rst;
    logic        irq;
    logic        sig_seen;
    logic        lock_seen;
  } rcs_state_t;

  rcs_state_t st_q;
  rcs_state_t st_d;

  logic        access;
  logic        wr;
  logic        rd;
  logic [9:0]  addr;
  logic        in_page;
  logic        mapped;
  logic        regs_clr;
  logic        rd_flags;
  logic        sig_lost;
  logic        lock_lost;
  logic        sig_lost_rise;
  logic        lock_lost_rise;
  logic [7:0]  obs_val;
  logic [15:0] div_max;
  logic [7:0]  wbyte;

  // one hit per register word
  logic        hit_soft_rst;
  logic        hit_status;
  logic        hit_observe;
  logic        hit_obs_sel;
  logic        hit_load;
  logic        hit_speed;
  logic        hit_loss_en;
  logic        hit_irq_stat;
  logic        hit_irq_mask;

  // write enables of the writable words
  logic        we_soft_rst;
  logic        we_obs_sel;
  logic        we_speed;
  logic        we_loss_en;
  logic        we_irq_stat;
  logic        we_irq_mask;

  // ****************************************************************
  // bus access
  // ****************************************************************
  // taken once: the answer cycle itself is not a second access
  assign access = psel && penable && !st_q.ready;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;
  assign addr   = paddr[9:0];
  assign wbyte  = pwdata[7:0];
  // RL4 register reset
  assign regs_clr = st_q.soft_rst[rcs_pkg::BIT_RST_REGS];
  assign rd_flags = rd && hit_status;

  // ****************************************************************
  // sticky loss flags
  // ****************************************************************
  // RL8 signal lost
  rcs_loss_flag u_sig_loss (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .sync_clr (regs_clr),
    .enable   (st_q.loss_en[rcs_pkg::BIT_EN_SIG_LOSS]),
    .level    (raw_input_present),
    .read_clr (rd_flags),
    .flag     (sig_lost)
  );

  // RL7 lock lost
  rcs_loss_flag u_lock_loss (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .sync_clr (regs_clr),
    .enable   (st_q.loss_en[rcs_pkg::BIT_EN_LOCK_LOSS]),
    .level    (cdr_locked),
    .read_clr (rd_flags),
    .flag     (lock_lost)
  );

  // ****************************************************************
  // observation mux
  // ****************************************************************
  always_comb begin
    // RL11 group select
    obs_val = observe_groups[
      {st_q.obs_sel[rcs_pkg::BIT_SEL_LSB +: 4], 3'h0} +: 8];
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  // only the lowest kilobyte decodes, so no upper alias hits a register
  assign in_page      = paddr[11:10] == 2'b00;
  assign hit_soft_rst = in_page && addr == rcs_pkg::ADDR_SOFT_RESET;
  assign hit_status   = in_page && addr == rcs_pkg::ADDR_SIGNAL_PRBS;
  assign hit_observe  = in_page && addr == rcs_pkg::ADDR_OBSERVE;
  assign hit_obs_sel  = in_page && addr == rcs_pkg::ADDR_OBSERVE_SEL;
  assign hit_load     = in_page && addr == rcs_pkg::ADDR_LOAD_STATUS;
  assign hit_speed    = in_page && addr == rcs_pkg::ADDR_I2C_SPEED;
  assign hit_loss_en  = in_page && addr == rcs_pkg::ADDR_LOSS_ENABLE;
  assign hit_irq_stat = in_page && addr == rcs_pkg::ADDR_IRQ_STATUS;
  assign hit_irq_mask = in_page && addr == rcs_pkg::ADDR_IRQ_MASK;
  assign mapped = hit_soft_rst ||
                  hit_status ||
                  hit_observe ||
                  hit_obs_sel ||
                  hit_load ||
                  hit_speed ||
                  hit_loss_en ||
                  hit_irq_stat ||
                  hit_irq_mask;

  // every register sits in byte lane 0
  assign we_soft_rst = wr && pstrb[0] && hit_soft_rst;
  assign we_obs_sel  = wr && pstrb[0] && hit_obs_sel;
  assign we_speed    = wr && pstrb[0] && hit_speed;
  assign we_loss_en  = wr && pstrb[0] && hit_loss_en;
  assign we_irq_stat = wr && pstrb[0] && hit_irq_stat;
  assign we_irq_mask = wr && pstrb[0] && hit_irq_mask;

  // ****************************************************************
  // loss flag edges
  // ****************************************************************
  // a flag that rises posts its event once to the interrupt status
  assign sig_lost_rise  = sig_lost && !st_q.sig_seen;
  assign lock_lost_rise = lock_lost && !st_q.lock_seen;

  // ****************************************************************
  // rate divider
  // ****************************************************************
  // RL2 rate select
  assign div_max = st_q.i2c_speed[rcs_pkg::BIT_I2C_FAST] ?
                   16'(DIV_FAST - 1) : 16'(DIV_STD - 1);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_d       = st_q;
    st_d.ready = access;
    st_d.slverr = access && !mapped;
    st_d.rdata = 32'h0000_0000;

    if (rd && mapped) begin
      case (addr)
        rcs_pkg::ADDR_SOFT_RESET:  st_d.rdata[7:0] = st_q.soft_rst;
        rcs_pkg::ADDR_SIGNAL_PRBS: begin
          // RL12 raw detector
          st_d.rdata[rcs_pkg::BIT_RAW_PRESENT] = raw_input_present;
          // RL10 polarity inverted
          st_d.rdata[rcs_pkg::BIT_PAT_INV]     = pattern_inverted_flag;
          st_d.rdata[rcs_pkg::BIT_LOCK_LOST]   = lock_lost;
          // RL9 pattern code
          st_d.rdata[rcs_pkg::BIT_PAT_LSB +: 4] =
            detected_pattern_code[3] ? detected_pattern_code
                                     : rcs_pkg::RCS_PAT_NONE;
          st_d.rdata[rcs_pkg::BIT_SIG_LOST]    = sig_lost;
        end
        rcs_pkg::ADDR_OBSERVE:     st_d.rdata[7:0] = obs_val;
        rcs_pkg::ADDR_OBSERVE_SEL: st_d.rdata[7:0] = st_q.obs_sel;
        rcs_pkg::ADDR_LOAD_STATUS: begin
          // RL13 load status
          st_d.rdata[rcs_pkg::BIT_LOAD_DONE] = load_done_flag;
          st_d.rdata[rcs_pkg::BIT_LOAD_FAIL] = load_failed_flag;
          // RL1 attempt count
          st_d.rdata[5:0] = st_q.attempts;
        end
        rcs_pkg::ADDR_I2C_SPEED:   st_d.rdata[7:0] = st_q.i2c_speed;
        rcs_pkg::ADDR_LOSS_ENABLE: st_d.rdata[7:0] = st_q.loss_en;
        rcs_pkg::ADDR_IRQ_STATUS:  st_d.rdata[1:0] = st_q.irq_stat;
        rcs_pkg::ADDR_IRQ_MASK:    st_d.rdata[1:0] = st_q.irq_mask;
        default:                   st_d.rdata = 32'h0000_0000;
      endcase
    end

    // RL14 reset bits hold
    if (we_soft_rst) begin
      st_d.soft_rst = wbyte;
    end
    if (we_obs_sel) begin
      st_d.obs_sel = wbyte;
    end
    if (we_speed) begin
      st_d.i2c_speed = wbyte;
    end
    if (we_loss_en) begin
      st_d.loss_en = wbyte;
    end
    if (we_irq_mask) begin
      st_d.irq_mask = wbyte[1:0];
    end

    // write one to clear, new event wins
    if (we_irq_stat) begin
      st_d.irq_stat = st_q.irq_stat & ~wbyte[1:0];
    end
    if (sig_lost_rise) begin
      st_d.irq_stat[0] = 1'b1;
    end
    if (lock_lost_rise) begin
      st_d.irq_stat[1] = 1'b1;
    end
    st_d.sig_seen  = sig_lost;
    st_d.lock_seen = lock_lost;

    // RL1 count attempts
    // saturates so a long retry run cannot wrap to a small count
    if (load_attempt_pulse && st_q.attempts != rcs_pkg::MAX_LOAD_TRIES) begin
      st_d.attempts = st_q.attempts + 6'h01;
    end

    // restarts at once when the limit is lowered below the count
    if (st_q.div_cnt >= div_max) begin
      st_d.div_cnt = 16'h0000;
      st_d.tick    = 1'b1;
    end else begin
      st_d.div_cnt = st_q.div_cnt + 16'h0001;
      st_d.tick    = 1'b0;
    end

    // RL4 registers to defaults
    if (regs_clr && !we_soft_rst) begin
      st_d.soft_rst  = rcs_pkg::RST_SOFT_RESET;
      st_d.obs_sel   = rcs_pkg::RST_OBS_SEL;
      st_d.loss_en   = rcs_pkg::RST_LOSS_EN;
      st_d.irq_stat  = rcs_pkg::RST_IRQ;
      st_d.irq_mask  = rcs_pkg::RST_IRQ;
    end

    // RL3 core domain reset
    st_d.core_rst  = st_d.soft_rst[rcs_pkg::BIT_RST_CORE];
    // RL5 recovered clock reset
    st_d.recov_rst = st_d.soft_rst[rcs_pkg::BIT_RST_RECOV];
    // RL6 only with ref clock
    // gated by the clock detector, the domain has no edges otherwise
    st_d.ref_rst   = st_d.soft_rst[rcs_pkg::BIT_REF_DOMAIN_SOFT_RESET] &&
                     ref_clk_present;
    st_d.irq       = |(st_d.irq_stat & st_d.irq_mask);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q           <= '0;
      // the speed register alone powers up non-zero
      st_q.i2c_speed <= rcs_pkg::RST_I2C_SPEED;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata                   = st_q.rdata;
  assign pready                   = st_q.ready;
  assign pslverr                  = st_q.slverr;
  assign i2c_scl_tick             = st_q.tick;
  assign i2c_fast_mode            = st_q.i2c_speed[rcs_pkg::BIT_I2C_FAST];
  assign core_domain_reset        = st_q.core_rst;
  assign recovered_clk_soft_reset = st_q.recov_rst;
  assign ref_domain_soft_reset    = st_q.ref_rst;
  assign irq                      = st_q.irq;

endmodule

//--- test/rcs_channel_regs_checker.sv
module rcs_checker #(
  parameter int unsigned DIV_FAST = 4,
  parameter int unsigned DIV_STD  = 8
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // status and outputs
  input wire logic        raw_input_present,
  input wire logic        pattern_inverted_flag,
  input wire logic [3:0]  detected_pattern_code,
  input wire logic        load_done_flag,
  input wire logic        load_failed_flag,
  input wire logic        i2c_fast_mode,
  input wire logic        core_domain_reset,
  input wire logic        recovered_clk_soft_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ack;
  logic rd_st;
  logic rd_ld;
  logic wr_sr;
  logic wr_sp;
  assign ack = psel & penable & pready & ~pslverr & clk_en;
  assign rd_st = ack & ~pwrite & (paddr == 12'h004);
  assign rd_ld = ack & ~pwrite & (paddr == 12'h044);
  assign wr_sr = ack & pwrite & pstrb[0] & (paddr == 12'h000);
  assign wr_sp = ack & pwrite & pstrb[0] & (paddr == 12'h048);
  property p_raw;
    rd_st |-> prdata[7] == $past(raw_input_present);
  endproperty
  a_raw: assert property (p_raw) else $error("raw detect bit wrong");
  property p_inv;
    rd_st |-> prdata[6] == $past(pattern_inverted_flag);
  endproperty
  a_inv: assert property (p_inv) else $error("inversion bit wrong");
  property p_pat;
    rd_st |-> prdata[4:1] == ($past(detected_pattern_code[3]) ?
      $past(detected_pattern_code) : 4'h0);
  endproperty
  a_pat: assert property (p_pat) else $error("pattern field wrong");
  property p_load;
    rd_ld |-> prdata[7:6] == {$past(load_done_flag), $past(load_failed_flag)};
  endproperty
  a_load: assert property (p_load) else $error("load status wrong");
  property p_core;
    wr_sr |=> core_domain_reset == $past(pwdata[3]);
  endproperty
  a_core: assert property (p_core) else $error("core reset wrong");
  property p_recov;
    wr_sr |=> recovered_clk_soft_reset == $past(pwdata[1]);
  endproperty
  a_recov: assert property (p_recov) else $error("recov reset wrong");
  property p_hold;
    core_domain_reset & clk_en & ~(psel & pwrite & (paddr == 12'h000))
      |=> core_domain_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("core reset dropped");
  property p_fast;
    wr_sp & pwdata[7] |-> ##[1:2] i2c_fast_mode;
  endproperty
  a_fast: assert property (p_fast) else $error("fast mode not set");
endmodule

bind rcs_channel_regs rcs_checker #(.DIV_FAST(DIV_FAST), .DIV_STD(DIV_STD))
  i_chk (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .clk_en                   (clk_en),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .pstrb                    (pstrb),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .raw_input_present        (raw_input_present),
    .pattern_inverted_flag    (pattern_inverted_flag),
    .detected_pattern_code    (detected_pattern_code),
    .load_done_flag           (load_done_flag),
    .load_failed_flag         (load_failed_flag),
    .i2c_fast_mode            (i2c_fast_mode),
    .core_domain_reset        (core_domain_reset),
    .recovered_clk_soft_reset (recovered_clk_soft_reset)
  );

//--- test/tb_rcs_channel_regs.sv
module tb_rcs_channel_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DF = 4;
  localparam int DS = 8;
  localparam logic [11:0] A_SR = 12'h000;
  localparam logic [11:0] A_ST = 12'h004;
  localparam logic [11:0] A_OB = 12'h008;
  localparam logic [11:0] A_OS = 12'h030;
  localparam logic [11:0] A_LS = 12'h044;
  localparam logic [11:0] A_SP = 12'h048;
  localparam logic [11:0] A_EN = 12'h0C4;
  localparam logic [11:0] A_IS = 12'h100;
  localparam logic [11:0] A_IM = 12'h104;
  logic [3:0] pats [9] = '{4'h0, 4'h8, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE,
                           4'hF, 4'h5};
  logic         pclk, presetn, psel, penable, pwrite, e, ce;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, r;
  logic [3:0]   pstrb, pat;
  logic         pready, pslverr, raw, lock, inv, att, done, fail, refp;
  logic [127:0] obs;
  logic         tick, fast, core_r, rec_r, ref_r, irq;
  int           n_fail, cmp_count, g;

  rcs_channel_regs #(.DIV_FAST(DF), .DIV_STD(DS)) i_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_input_present(raw), .cdr_locked(lock),
    .pattern_inverted_flag(inv), .detected_pattern_code(pat),
    .observe_groups(obs), .ref_clk_present(refp),
    .load_attempt_pulse(att), .load_done_flag(done),
    .load_failed_flag(fail), .i2c_scl_tick(tick), .i2c_fast_mode(fast),
    .core_domain_reset(core_r), .recovered_clk_soft_reset(rec_r),
    .ref_domain_soft_reset(ref_r), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task report_and_stop;
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk({e, r[30:0]}, exp);
  endtask

  task automatic gap;
    g = 0;
    while (tick !== 1'b1 && g < 100) begin
      @(posedge pclk);
      g++;
    end
    g = 0;
    do begin
      @(posedge pclk);
      g++;
    end while (tick !== 1'b1 && g < 100);
  endtask

  initial begin
    {psel, penable, pwrite, raw, lock, inv, att, done, fail} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    ce = 1'b1;
    pat = '0;
    refp = 1'b1;
    for (int i = 0; i < 16; i++) obs[8*i+:8] = 8'(i * 17 + 3);
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_SR, 32'h0); rd(A_SP, 32'h91); rd(A_EN, 32'h0);
    rd(A_IM, 32'h0); rd(A_IS, 32'h0); rd(A_OS, 32'h0);
    rd(12'h3F0, 32'h8000_0000);
    rd(12'h404, 32'h8000_0000);
    raw <= 1'b1;
    inv <= 1'b1;
    foreach (pats[i]) begin
      pat <= pats[i];
      rd(A_ST, {24'h0, 3'b110, pats[i][3] ? pats[i] : 4'h0, 1'b0});
    end
    raw <= 1'b0;
    inv <= 1'b0;
    rd(A_ST, 32'h0);
    wr_en: apb(1'b1, A_EN, 32'h3);
    raw <= 1'b1;
    lock <= 1'b1;
    rd(A_ST, 32'h80);
    raw <= 1'b0;
    lock <= 1'b0;
    rd(A_ST, 32'h21); rd(A_ST, 32'h0); rd(A_IS, 32'h3);
    chk(irq, 0);
    apb(1'b1, A_IM, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    apb(1'b1, A_IS, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    rd(A_IS, 32'h2);
    done <= 1'b1;
    for (int i = 0; i < 65; i++) begin
      @(posedge pclk) att <= 1'b1;
      @(posedge pclk) att <= 1'b0;
      if (i == 4) rd(A_LS, 32'h85);
      if (i == 4) {done, fail} <= 2'b01;
    end
    rd(A_LS, 32'h7F);
    apb(1'b1, A_SR, 32'h0B);
    repeat (2) @(posedge pclk);
    chk({core_r, rec_r, ref_r}, 3'b111);
    rd(A_SR, 32'h0B);
    apb(1'b1, A_SR, 32'h0);
    repeat (2) @(posedge pclk);
    chk({core_r, rec_r, ref_r}, 3'b000);
    refp <= 1'b0;
    apb(1'b1, A_SR, 32'h1);
    repeat (2) @(posedge pclk);
    chk(ref_r, 0);
    refp <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(ref_r, 1);
    apb(1'b1, A_SR, 32'h0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, A_OS, 32'(i << 4));
      rd(A_OB, 32'(obs[8*i+:8]));
    end
    apb(1'b1, A_EN, 32'h3);
    apb(1'b1, A_SR, 32'h4);
    repeat (3) @(posedge pclk);
    rd(A_SR, 32'h0); rd(A_OS, 32'h0); rd(A_EN, 32'h0);
    pstrb <= 4'hE;
    apb(1'b1, A_OS, 32'h50);
    pstrb <= 4'hF;
    rd(A_OS, 32'h0);
    gap;
    chk(g, DF);
    chk(fast, 1);
    apb(1'b1, A_SP, 32'h11);
    gap;
    gap;
    chk(g, DS);
    ce <= 1'b0;
    g = 0;
    repeat (20) begin
      @(posedge pclk);
      if (tick !== 1'b0) g++;
    end
    ce <= 1'b1;
    chk(g, 0);
    chk(fast, 0);
    rd(A_SP, 32'h11);
    apb(1'b1, A_SP, 32'h91);
    chk(fast, 1);
    report_and_stop;
  end

  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
endmodule
